// [wdr_pkg.sv]
// Watchdog reset timer constants and types
package wdr_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] MASK_OFF = 8'h08;
  localparam logic [7:0] LOCK_OFF = 8'h0c;
  localparam logic [7:0] CNT_OFF = 8'h10;
  localparam logic [31:0] CTL_RESET = 32'h0000_0700;
  // Control field positions
  localparam int SEL_LSB = 8;
  localparam int RUN_BIT = 7;
  localparam int IRQEN_BIT = 6;
  localparam int TFLAG_BIT = 3;
  localparam int RFLAG_BIT = 2;
  localparam int CLR_BIT = 0;
  // Status and mask bits
  localparam int EV_TIMEOUT = 0;
  localparam int EV_RESET = 1;
  // Unlock keys; values are arbitrary
  localparam logic [7:0] KEY0 = 8'ha5;
  localparam logic [7:0] KEY1 = 8'h5a;
  localparam logic [7:0] KEY2 = 8'h3c;
  // ************************************************************
  // Counts in watchdog ticks
  // ************************************************************
  localparam int CNT_W = 18;
  localparam int BASE_EXP = 4;
  localparam logic [9:0] GRACE_LAST = 10'h3ff;
  localparam logic [5:0] HOLD_LAST = 6'h3f;
  localparam int TICK_DIV = 1;
  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [2:0] {
    ST_COUNT = 3'h1,
    ST_GRACE = 3'h2,
    ST_HOLD = 3'h4
  } wdr_fsm_t;
  typedef struct packed {
    wdr_fsm_t fsm;
    logic [CNT_W-1:0] cnt;
    logic [9:0] grace;
    logic [5:0] hold;
    logic run_en;
    logic irq_en;
    logic [2:0] sel;
    logic clr_req;
    logic tflag;
    logic rflag;
    logic [1:0] stat;
    logic [1:0] mask;
    logic unlock;
    logic [1:0] key_idx;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic cpu_rst;
  } wdr_state_t;
endpackage

// [wdr_tick_div.sv]
// Tick enable divider for the watchdog clock
`timescale 1ns/100ps
module wdr_tick_div #(
  parameter int DIV = wdr_pkg::TICK_DIV
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  output logic tick_o
);
  initial begin
    if (DIV < 1 || DIV > 65536) begin
      $error("wdr_tick_div: DIV out of range");
    end
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wdr_div_t;

  localparam logic [15:0] LAST = 16'(DIV - 1);

  wdr_div_t s_reg;
  wdr_div_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = (s_reg.cnt == LAST);
    s_next.cnt = s_next.tick ? 16'h0000 : s_reg.cnt + 16'h0001;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;
endmodule // wdr_tick_div

// [wdr_watchdog.sv]
// Watchdog reset timer with APB register access
//
// Function
// - Setting run_enable makes the counter step up on each watchdog tick.
// - The counter is an 18-bit free-running up-counter with a selectable interval.
// - Reaching the interval sets the timeout flag at once and requests an interrupt if enabled.
// - interval_select picks 2^(2n+4) ticks, from 16 for code 000 to 2^18 for code 111.
// - After each interval timeout a further 1024 ticks pass before the reset deadline.
// - Writing counter_clear_request high before the deadline zeroes the counter.
// - counter_clear_request falls back to zero by itself once the counter was zeroed.
// - Missing the deadline sets reset_occurred_flag and resets the processor.
// - The processor reset lasts 64 ticks, after which code restarts at address zero.
// - reset_occurred_flag survives the watchdog reset so software can see the cause.
// - The timeout flag stays set until a one is written to it; a zero leaves it.
// - Clearing run_enable zeroes the counter and ends a grace period; a processor reset already under way still runs its 64 ticks.
// - Control bits take writes only when unlocked; both flags clear by one at any time.
// - The timeout flag is set at every interval timeout even with the interrupt off.
`timescale 1ns/100ps
module wdr_watchdog #(
  parameter int TICK_DIV = wdr_pkg::TICK_DIV
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic cpu_reset_o
);
  // ************************************************************
  // Elaboration checks
  // ************************************************************
  initial begin
    if (TICK_DIV < 1) begin
      $error("wdr_watchdog: TICK_DIV must be at least 1");
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Last count value of the selected interval
  function automatic logic [wdr_pkg::CNT_W-1:0] interval_last(input logic [2:0] sel);
    logic [wdr_pkg::CNT_W:0] span;
    span = (wdr_pkg::CNT_W+1)'(1) << (wdr_pkg::BASE_EXP + 2 * int'(sel));
    interval_last = wdr_pkg::CNT_W'(span - (wdr_pkg::CNT_W+1)'(1));
  endfunction

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == wdr_pkg::CTL_OFF) || (a == wdr_pkg::STAT_OFF) ||
             (a == wdr_pkg::MASK_OFF) || (a == wdr_pkg::LOCK_OFF) ||
             (a == wdr_pkg::CNT_OFF);
  endfunction

  // ************************************************************
  // Tick divider
  // ************************************************************
  logic tick;

  wdr_tick_div #(
    .DIV(TICK_DIV)
  ) u_div (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .tick_o(tick)
  );

  // ************************************************************
  // State
  // ************************************************************
  wdr_pkg::wdr_state_t s_reg;
  wdr_pkg::wdr_state_t s_next;

  logic setup;
  logic wr_done;
  logic wr_ctl;
  logic wr_stat;
  logic wr_mask;
  logic wr_lock;
  logic ctl_ok;
  logic at_interval;
  logic timeout_ev;
  logic reset_ev;
  logic [31:0] ctl_view;
  logic [31:0] rd_val;

  always_comb begin
    ctl_view = '0;
    ctl_view[wdr_pkg::SEL_LSB +: 3] = s_reg.sel;
    ctl_view[wdr_pkg::RUN_BIT] = s_reg.run_en;
    ctl_view[wdr_pkg::IRQEN_BIT] = s_reg.irq_en;
    ctl_view[wdr_pkg::TFLAG_BIT] = s_reg.tflag;
    ctl_view[wdr_pkg::RFLAG_BIT] = s_reg.rflag;
    ctl_view[wdr_pkg::CLR_BIT] = s_reg.clr_req;
  end

  always_comb begin
    unique case (paddr_i)
      wdr_pkg::CTL_OFF: rd_val = ctl_view;
      wdr_pkg::STAT_OFF: rd_val = {30'h0, s_reg.stat};
      wdr_pkg::MASK_OFF: rd_val = {30'h0, s_reg.mask};
      wdr_pkg::LOCK_OFF: rd_val = {31'h0, s_reg.unlock};
      wdr_pkg::CNT_OFF: rd_val = {14'h0, s_reg.cnt};
      default: rd_val = 32'h0;
    endcase
  end

  always_comb begin
    // Access phase starts; answer one cycle later
    setup = psel_i && penable_i && !s_reg.pready;
    wr_done = psel_i && penable_i && s_reg.pready && pwrite_i;
    wr_ctl = wr_done && (paddr_i == wdr_pkg::CTL_OFF);
    wr_stat = wr_done && (paddr_i == wdr_pkg::STAT_OFF);
    wr_mask = wr_done && (paddr_i == wdr_pkg::MASK_OFF);
    wr_lock = wr_done && (paddr_i == wdr_pkg::LOCK_OFF);
    ctl_ok = wr_ctl && s_reg.unlock;
    at_interval = s_reg.cnt == interval_last(s_reg.sel);
    timeout_ev = 1'b0;
    reset_ev = 1'b0;

    s_next = s_reg;

    // ************************************************************
    // APB answer
    // ************************************************************
    s_next.pready = setup;
    if (setup) begin
      s_next.pslverr = !is_reg(paddr_i);
      s_next.prdata = pwrite_i ? 32'h0 : rd_val;
    end else begin
      s_next.pslverr = 1'b0;
      s_next.prdata = 32'h0;
    end

    // ************************************************************
    // Unlock sequence: three keys in a row
    // ************************************************************
    if (wr_lock) begin
      if (s_reg.unlock) begin
        // Any write relocks, so a runaway store cannot keep it open
        s_next.unlock = 1'b0;
        s_next.key_idx = 2'h0;
      end else begin
        unique case (s_reg.key_idx)
          2'h0: s_next.key_idx = (pwdata_i[7:0] == wdr_pkg::KEY0) ? 2'h1 : 2'h0;
          2'h1: s_next.key_idx = (pwdata_i[7:0] == wdr_pkg::KEY1) ? 2'h2 : 2'h0;
          2'h2: begin
            s_next.unlock = pwdata_i[7:0] == wdr_pkg::KEY2;
            s_next.key_idx = 2'h0;
          end
          default: s_next.key_idx = 2'h0;
        endcase
      end
    end

    // ************************************************************
    // Control writes
    // ************************************************************
    if (ctl_ok) begin
      s_next.sel = pwdata_i[wdr_pkg::SEL_LSB +: 3];
      s_next.run_en = pwdata_i[wdr_pkg::RUN_BIT];
      s_next.irq_en = pwdata_i[wdr_pkg::IRQEN_BIT];
    end
    if (wr_mask) begin
      s_next.mask = pwdata_i[1:0];
    end

    // ************************************************************
    // Counter and deadline
    // ************************************************************
    if (s_reg.clr_req) begin
      s_next.cnt = '0;
      s_next.clr_req = 1'b0;
      if (s_reg.fsm == wdr_pkg::ST_GRACE) begin
        s_next.fsm = wdr_pkg::ST_COUNT;
        s_next.grace = '0;
      end
    end else if (!s_reg.run_en) begin
      s_next.cnt = '0;
      s_next.grace = '0;
      if (s_reg.fsm == wdr_pkg::ST_GRACE) begin
        s_next.fsm = wdr_pkg::ST_COUNT;
      end
    end else if (tick) begin
      unique case (s_reg.fsm)
        wdr_pkg::ST_COUNT: begin
          s_next.cnt = s_reg.cnt + 1'b1;
          if (at_interval) begin
            timeout_ev = 1'b1;
            s_next.fsm = wdr_pkg::ST_GRACE;
            s_next.grace = '0;
          end
        end
        wdr_pkg::ST_GRACE: begin
          s_next.cnt = s_reg.cnt + 1'b1;
          if (s_reg.grace == wdr_pkg::GRACE_LAST) begin
            reset_ev = 1'b1;
            s_next.fsm = wdr_pkg::ST_HOLD;
            s_next.hold = '0;
            s_next.cnt = '0;
          end else begin
            s_next.grace = s_reg.grace + 1'b1;
          end
        end
        wdr_pkg::ST_HOLD: begin
          // Counter parked while the processor is held
          s_next.cnt = '0;
        end
        default: s_next.fsm = wdr_pkg::ST_COUNT;
      endcase
    end

    // Hold runs on ticks even with run_enable low
    if (s_reg.fsm == wdr_pkg::ST_HOLD && tick) begin
      if (s_reg.hold == wdr_pkg::HOLD_LAST) begin
        s_next.fsm = wdr_pkg::ST_COUNT;
        s_next.hold = '0;
      end else begin
        s_next.hold = s_reg.hold + 1'b1;
      end
    end
    s_next.cpu_rst = (s_next.fsm == wdr_pkg::ST_HOLD);

    // Clear request taken last; it acts on the following cycle
    if (ctl_ok && pwdata_i[wdr_pkg::CLR_BIT]) begin
      s_next.clr_req = 1'b1;
    end

    // ************************************************************
    // Flags: set wins over a same-cycle clear
    // ************************************************************
    if (wr_ctl && pwdata_i[wdr_pkg::TFLAG_BIT]) begin
      s_next.tflag = 1'b0;
    end
    if (wr_ctl && pwdata_i[wdr_pkg::RFLAG_BIT]) begin
      s_next.rflag = 1'b0;
    end
    if (wr_stat) begin
      s_next.stat = s_reg.stat & ~pwdata_i[1:0];
    end
    if (timeout_ev) begin
      s_next.tflag = 1'b1;
      s_next.stat[wdr_pkg::EV_TIMEOUT] = 1'b1;
    end
    if (reset_ev) begin
      // Writing a one or system reset clears it; the processor reset does not
      s_next.rflag = 1'b1;
      s_next.stat[wdr_pkg::EV_RESET] = 1'b1;
    end

    // ************************************************************
    // Interrupt
    // ************************************************************
    s_next.irq = (s_next.tflag && s_next.irq_en) ||
                 (|(s_next.stat & s_next.mask));
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
      s_reg.fsm <= wdr_pkg::ST_COUNT;
      s_reg.sel <= wdr_pkg::CTL_RESET[wdr_pkg::SEL_LSB +: 3];
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata_o = s_reg.prdata;
  assign pready_o = s_reg.pready;
  assign pslverr_o = s_reg.pslverr;
  assign irq_o = s_reg.irq;
  assign cpu_reset_o = s_reg.cpu_rst;
endmodule // wdr_watchdog

// [wdr_watchdog_properties.sv]
// Port checker for the watchdog reset timer
`timescale 1ns/100ps
module wdr_watchdog_properties #(
  parameter int TICK_DIV = 1
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic irq_o,
  input wire logic cpu_reset_o
);
  // ********
  // Helpers
  // ********
  logic [15:0] hold_reg;
  logic acc;
  assign acc = psel_i && penable_i && !pready_o;
  // Counts consecutive cycles of processor reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_reg <= 16'h0000;
    end else begin
      hold_reg <= cpu_reset_o ? hold_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ********
  // Assertions
  // ********
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
  ready_time_a: assert property (acc |=> pready_o) else $error("ready late");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data idle");
  err_unmap_a: assert property (acc && paddr_i > 8'h10 |=> pslverr_o) else $error("no error");
  ok_mapped_a: assert property (acc && paddr_i[1:0] == 2'h0 && paddr_i <= 8'h10
    |=> !pslverr_o) else $error("false error");
  hold_len_a: assert property ($fell(cpu_reset_o) |-> hold_reg == 64 * TICK_DIV)
    else $error("reset hold length");
  hold_max_a: assert property (hold_reg <= 64 * TICK_DIV) else $error("reset too long");
  cover property ($rose(cpu_reset_o));
  cover property ($rose(irq_o));
  cover property (pslverr_o);
endmodule // wdr_watchdog_properties

bind wdr_watchdog wdr_watchdog_properties #(.TICK_DIV(TICK_DIV)) chk (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o)
);

// [wdr_watchdog_tb.sv]
// Self-checking testbench for the watchdog reset timer
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, sn); end end
module wdr_watchdog_tb;
  localparam logic [7:0] CTL = wdr_pkg::CTL_OFF;
  localparam logic [7:0] STA = wdr_pkg::STAT_OFF;
  localparam logic [7:0] MSK = wdr_pkg::MASK_OFF;
  localparam logic [7:0] LCK = wdr_pkg::LOCK_OFF;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic irq_o;
  logic cpu_reset_o;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  wdr_watchdog #(.TICK_DIV(1)) uut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o)
  );
  // ********
  // Bus cycle, waits, verdict
  // ********
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    `CHK("ready seen", 1'b1, pready_o)
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle cycle so strobes never toggle twice in one step
    @(posedge ref_clk_i);
  endtask
  task automatic wait_for(input bit rst, input logic lvl, input int lim, output int n);
    n = 0;
    while ((rst ? cpu_reset_o : irq_o) !== lvl && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_lock();
    apb(1'b0, CTL, 32'h0);
    `CHK("ctl reset", 32'h0000_0700, rd)
    apb(1'b1, CTL, 32'h0000_00c0);
    apb(1'b0, CTL, 32'h0);
    `CHK("ctl locked", 32'h0000_0700, rd)
    apb(1'b1, LCK, {24'h0, wdr_pkg::KEY0});
    apb(1'b1, LCK, {24'h0, wdr_pkg::KEY1});
    apb(1'b1, LCK, {24'h0, wdr_pkg::KEY2});
    apb(1'b1, 8'h20, 32'h1);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b0, 8'h24, 32'h0);
    `CHK("unmapped data", 32'h0, rd)
  endtask
  task automatic t_interval(input logic [2:0] s);
    int n;
    int t;
    logic [31:0] c;
    t = 1 << (2 * s + 4);
    c = {21'h0, s, 8'h00};
    apb(1'b1, CTL, c);
    apb(1'b0, wdr_pkg::CNT_OFF, 32'h0);
    `CHK("stopped count", 32'h0, rd)
    apb(1'b1, CTL, c | 32'h0000_00c0);
    wait_for(1'b0, 1'b1, t + 40, n);
    `CHK("interval", 1'b1, n >= t - 4 && n <= t + 4)
    apb(1'b1, CTL, c | 32'h0000_00c9);
    apb(1'b0, wdr_pkg::CNT_OFF, 32'h0);
    `CHK("cleared count", 1'b1, rd < 32'h10)
    apb(1'b0, CTL, 32'h0);
    `CHK("ctl after clear", c | 32'h0000_00c0, rd)
    `CHK("irq after clear", 1'b0, irq_o)
  endtask
  task automatic t_noirq();
    int n;
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, CTL, 32'h0000_0080);
    wait_for(1'b0, 1'b1, 24, n);
    `CHK("irq off", 1'b0, irq_o)
    apb(1'b1, CTL, 32'h0000_0080);
    apb(1'b0, CTL, 32'h0);
    `CHK("flag kept", 32'h0000_0088, rd)
  endtask
  task automatic t_deadline();
    int n;
    // Stop first so the grace period left by the last scenario is aborted
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, CTL, 32'h0000_00c8);
    wait_for(1'b0, 1'b1, 60, n);
    wait_for(1'b1, 1'b1, 1100, n);
    `CHK("deadline", 1'b1, n >= 1020 && n <= 1028)
    wait_for(1'b1, 1'b0, 100, n);
    `CHK("hold", 1'b1, n >= 63 && n <= 65)
    apb(1'b0, CTL, 32'h0);
    `CHK("reset flag", 1'b1, rd[2])
    apb(1'b0, STA, 32'h0);
    `CHK("reset event", 1'b1, rd[1])
    apb(1'b1, CTL, 32'h0000_000c);
    apb(1'b0, CTL, 32'h0);
    `CHK("flags cleared", 32'h0, rd)
    apb(1'b1, MSK, 32'h2);
    repeat (2) @(posedge ref_clk_i);
    `CHK("irq unmasked", 1'b1, irq_o)
    apb(1'b1, MSK, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    `CHK("irq masked", 1'b0, irq_o)
    apb(1'b1, MSK, 32'h3);
    apb(1'b1, STA, 32'h3);
    repeat (2) @(posedge ref_clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    apb(1'b0, STA, 32'h0);
    `CHK("status cleared", 32'h0, rd)
  endtask
  // Only codes 0 to 3 are run; codes 5 and above would pass the 20000-cycle limit
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_lock();
    for (int s = 0; s < 4; s++) begin
      t_interval(3'(s));
    end
    t_noirq();
    t_deadline();
    results();
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
endmodule // wdr_watchdog_tb
